/* hdl/safe_speed_standstill_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module safe_speed_standstill_monitor #(
  parameter int unsigned CYCLES_MS = ssm_pkg::CYCLES_PER_MS  // clocks per millisecond
) (
  input  wire logic        clk_sys,       // system clock, 125 MHz
  input  wire logic        nrst,          // async reset, active low
  input  wire logic [7:0]  regAddr,       // register byte address
  input  wire logic [31:0] regWdata,      // write data
  input  wire logic        regWr,         // write strobe
  input  wire logic        regRd,         // read strobe
  output logic [31:0]      regRdata,      // read data, cycle after strobe
  input  wire logic [3:0]  safeInPin,     // safe inputs one..four, async
  input  wire logic [31:0] speedAbs,      // encoder speed magnitude
  input  wire logic [31:0] posDelta,      // position drift magnitude since stop
  output logic             speedFault,    // limited-speed fault, sticky
  output logic             torqueOffReq,  // reaction: torque off
  output logic             stopOneReq,    // reaction: safe stop one
  output logic             stopTwoReq,    // reaction: safe stop two
  output logic             speedMonitor,  // limited-speed final state
  output logic             stopActive,    // safe operating stop active
  output logic             stopViolation, // standstill window left
  output logic             irq            // level interrupt
);
  logic [31:0] dwellReg, deadlineReg, thresholdReg, posWinReg;
  logic [31:0] dwellNext, deadlineNext, thresholdNext, posWinNext;
  logic        fbusUseReg, armingReg, restartBehReg;
  logic        fbusUseNext, armingNext, restartBehNext;
  logic [2:0]  ackSelReg, trigSelReg, ackSelNext, trigSelNext;
  logic [1:0]  faultActReg, faultActNext;
  logic [2:0]  ctlReg, ctlNext;
  localparam int unsigned IRQ_W_T = ssm_pkg::IRQ_W;
  logic [IRQ_W_T-1:0] irqStatReg, irqStatNext, irqMaskReg, irqMaskNext;
  logic [31:0] rdataReg, rdataNext;

  // register file
  always_comb begin
    dwellNext = dwellReg;
    deadlineNext = deadlineReg;
    thresholdNext = thresholdReg;
    posWinNext = posWinReg;
    fbusUseNext = fbusUseReg;
    armingNext = armingReg;
    restartBehNext = restartBehReg;
    ackSelNext = ackSelReg;
    trigSelNext = trigSelReg;
    faultActNext = faultActReg;
    ctlNext = ctlReg;
    irqMaskNext = irqMaskReg;
    if (regWr) begin
      case (regAddr)
        ssm_pkg::OFS_DWELL: begin
          if (regWdata >= ssm_pkg::DWELL_MIN && regWdata <= ssm_pkg::TIME_MAX) dwellNext = regWdata;
        end
        ssm_pkg::OFS_DEADLINE: begin
          if (regWdata >= ssm_pkg::DEADLINE_MIN && regWdata <= ssm_pkg::TIME_MAX) deadlineNext = regWdata;
        end
        ssm_pkg::OFS_THRESHOLD: begin
          if (regWdata != 32'h0 && !regWdata[31]) thresholdNext = regWdata;
        end
        ssm_pkg::OFS_FBUS_USE: fbusUseNext = regWdata[0] & ctlReg[ssm_pkg::CTL_FBUS_EN];
        ssm_pkg::OFS_ARMING: armingNext = regWdata[0];
        ssm_pkg::OFS_POS_WINDOW: begin
          if (!regWdata[31]) posWinNext = regWdata;
        end
        ssm_pkg::OFS_RESTART_BEH: restartBehNext = regWdata[0];
        ssm_pkg::OFS_ACK_SELECT: begin
          if (regWdata <= 32'h6) ackSelNext = regWdata[2:0];
        end
        ssm_pkg::OFS_TRIG_SELECT: begin
          if (regWdata <= 32'h6) trigSelNext = regWdata[2:0];
        end
        ssm_pkg::OFS_FAULT_ACTION: begin
          if (regWdata >= 32'h1 && regWdata <= 32'h3) faultActNext = regWdata[1:0];
        end
        ssm_pkg::OFS_CONTROL: ctlNext = regWdata[2:0];
        ssm_pkg::OFS_IRQ_MASK: irqMaskNext = regWdata[IRQ_W_T-1:0];
        default: ;
      endcase
    end
    // fieldbus use falls back when the fieldbus is switched off
    if (!ctlNext[ssm_pkg::CTL_FBUS_EN]) fbusUseNext = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dwellReg <= ssm_pkg::RST_DWELL;
      deadlineReg <= ssm_pkg::RST_DEADLINE;
      thresholdReg <= ssm_pkg::RST_THRESHOLD;
      posWinReg <= ssm_pkg::RST_POS_WINDOW;
      fbusUseReg <= 1'b0;
      armingReg <= 1'b0;
      restartBehReg <= 1'b0;
      ackSelReg <= 3'h0;
      trigSelReg <= 3'h0;
      faultActReg <= ssm_pkg::RST_FAULT_ACTION;
      ctlReg <= 3'h0;
      irqMaskReg <= '0;
    end else begin
      dwellReg <= dwellNext;
      deadlineReg <= deadlineNext;
      thresholdReg <= thresholdNext;
      posWinReg <= posWinNext;
      fbusUseReg <= fbusUseNext;
      armingReg <= armingNext;
      restartBehReg <= restartBehNext;
      ackSelReg <= ackSelNext;
      trigSelReg <= trigSelNext;
      faultActReg <= faultActNext;
      ctlReg <= ctlNext;
      irqMaskReg <= irqMaskNext;
    end
  end

  // two-stage synchroniser on the safe inputs
  logic [3:0] sinMeta, sinSync;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      sinMeta <= 4'h0;
      sinSync <= 4'h0;
    end else begin
      sinMeta <= safeInPin;
      sinSync <= sinMeta;
    end
  end

  // dual channels count only when both agree
  function automatic logic pickInput(input logic [2:0] sel, input logic [3:0] sin);
    case (sel)
      3'h1: pickInput = sin[0];
      3'h2: pickInput = sin[1];
      3'h3: pickInput = sin[2];
      3'h4: pickInput = sin[3];
      ssm_pkg::SEL_DUAL12: pickInput = sin[0] & sin[1];
      ssm_pkg::SEL_DUAL34: pickInput = sin[2] & sin[3];
      default: pickInput = 1'b0;
    endcase
  endfunction : pickInput

  // millisecond tick
  logic [31:0] divReg, divNext;
  logic        msTick;
  assign msTick = (divReg == CYCLES_MS - 1);
  always_comb begin
    divNext = msTick ? 32'h0 : divReg + 32'h1;
  end

  // limited-speed sequencer
  ssm_pkg::speed_state_e spdReg, spdNext;
  logic inLimit;
  ms_timer_if dwellTmr ();
  ms_timer_if deadTmr ();
  ms_timer dwellTimer (.clk_sys(clk_sys), .nrst(nrst), .tmr(dwellTmr));
  ms_timer deadTimer (.clk_sys(clk_sys), .nrst(nrst), .tmr(deadTmr));
  assign inLimit = (speedAbs < thresholdReg);
  assign dwellTmr.tick = msTick;
  assign deadTmr.tick = msTick;
  // dwell restarts whenever velocity leaves the limit
  assign dwellTmr.run = (spdReg == ssm_pkg::SPD_WAIT) && inLimit;
  assign deadTmr.run = (spdReg == ssm_pkg::SPD_WAIT);

  always_comb begin
    spdNext = spdReg;
    case (spdReg)
      ssm_pkg::SPD_IDLE: if (ctlReg[ssm_pkg::CTL_SPEED_REQ]) spdNext = ssm_pkg::SPD_WAIT;
      ssm_pkg::SPD_WAIT: begin
        if (!ctlReg[ssm_pkg::CTL_SPEED_REQ]) spdNext = ssm_pkg::SPD_IDLE;
        else if (inLimit && dwellTmr.elapsed >= dwellReg) spdNext = ssm_pkg::SPD_MONITOR;
        else if (deadTmr.elapsed >= deadlineReg && !inLimit) spdNext = ssm_pkg::SPD_FAULT;
      end
      ssm_pkg::SPD_MONITOR: begin
        if (!ctlReg[ssm_pkg::CTL_SPEED_REQ]) spdNext = ssm_pkg::SPD_IDLE;
        else if (!inLimit) spdNext = ssm_pkg::SPD_FAULT;
      end
      // a fault holds until the request is withdrawn
      ssm_pkg::SPD_FAULT: if (!ctlReg[ssm_pkg::CTL_SPEED_REQ]) spdNext = ssm_pkg::SPD_IDLE;
      default: spdNext = ssm_pkg::SPD_IDLE;
    endcase
  end

  // safe operating stop
  logic stopReg, stopNext, trigIn, ackIn, stopAllowed, violReg, violNext;
  assign stopAllowed = armingReg && ctlReg[ssm_pkg::CTL_ENC_OK];
  assign trigIn = pickInput(trigSelReg, sinSync);
  assign ackIn = restartBehReg && pickInput(ackSelReg, sinSync);
  always_comb begin
    stopNext = stopReg;
    if (!stopAllowed) stopNext = 1'b0;
    else if (trigIn) stopNext = 1'b1;
    else if (!restartBehReg) stopNext = 1'b0;
    else if (ackIn) stopNext = 1'b0;
    violNext = violReg;
    if (!stopReg) violNext = 1'b0;
    else if (posDelta > posWinReg) violNext = 1'b1;
  end

  // interrupts: hardware set wins over software clear
  logic [IRQ_W_T-1:0] irqEvt;
  always_comb begin
    irqEvt = '0;
    irqEvt[ssm_pkg::IRQ_FAULT] = (spdNext == ssm_pkg::SPD_FAULT) && (spdReg != ssm_pkg::SPD_FAULT);
    irqEvt[ssm_pkg::IRQ_MONITOR] = (spdNext == ssm_pkg::SPD_MONITOR) && (spdReg != ssm_pkg::SPD_MONITOR);
    irqEvt[ssm_pkg::IRQ_STOP_ON] = stopNext && !stopReg;
    irqEvt[ssm_pkg::IRQ_STOP_VIOL] = violNext && !violReg;
    irqStatNext = irqStatReg;
    if (regWr && regAddr == ssm_pkg::OFS_IRQ_STATUS) irqStatNext = irqStatReg & ~regWdata[IRQ_W_T-1:0];
    irqStatNext = irqStatNext | irqEvt;
  end

  // read mux; unmapped addresses return zero
  always_comb begin
    rdataNext = 32'h0;
    if (regRd) begin
      case (regAddr)
        ssm_pkg::OFS_DWELL: rdataNext = dwellReg;
        ssm_pkg::OFS_DEADLINE: rdataNext = deadlineReg;
        ssm_pkg::OFS_THRESHOLD: rdataNext = thresholdReg;
        ssm_pkg::OFS_FBUS_USE: rdataNext = {31'h0, fbusUseReg};
        ssm_pkg::OFS_ARMING: rdataNext = {31'h0, armingReg};
        ssm_pkg::OFS_POS_WINDOW: rdataNext = posWinReg;
        ssm_pkg::OFS_RESTART_BEH: rdataNext = {31'h0, restartBehReg};
        ssm_pkg::OFS_ACK_SELECT: rdataNext = {29'h0, ackSelReg};
        ssm_pkg::OFS_TRIG_SELECT: rdataNext = {29'h0, trigSelReg};
        ssm_pkg::OFS_FAULT_ACTION: rdataNext = {30'h0, faultActReg};
        ssm_pkg::OFS_CONTROL: rdataNext = {29'h0, ctlReg};
        ssm_pkg::OFS_STATUS: rdataNext = {24'h0, sinSync, violReg, stopReg, spdReg};
        ssm_pkg::OFS_IRQ_STATUS: rdataNext = {{(32-IRQ_W_T){1'b0}}, irqStatReg};
        ssm_pkg::OFS_IRQ_MASK: rdataNext = {{(32-IRQ_W_T){1'b0}}, irqMaskReg};
        default: rdataNext = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      divReg <= 32'h0;
      spdReg <= ssm_pkg::SPD_IDLE;
      stopReg <= 1'b0;
      violReg <= 1'b0;
      irqStatReg <= '0;
      rdataReg <= 32'h0;
    end else begin
      divReg <= divNext;
      spdReg <= spdNext;
      stopReg <= stopNext;
      violReg <= violNext;
      irqStatReg <= irqStatNext;
      rdataReg <= rdataNext;
    end
  end

  logic faulted;
  assign faulted = (spdReg == ssm_pkg::SPD_FAULT);
  assign speedFault = faulted;
  assign torqueOffReq = faulted && faultActReg == ssm_pkg::REACT_TORQUE_OFF;
  assign stopOneReq = faulted && faultActReg == ssm_pkg::REACT_STOP_ONE;
  assign stopTwoReq = faulted && faultActReg == ssm_pkg::REACT_STOP_TWO;
  assign speedMonitor = (spdReg == ssm_pkg::SPD_MONITOR);
  assign stopActive = stopReg;
  assign stopViolation = violReg;
  assign irq = |(irqStatReg & irqMaskReg);
  assign regRdata = rdataReg;

  // assertions
  AST_FBUS_GATE: assert property (@(posedge clk_sys) disable iff (!nrst)
    fbusUseReg |-> ctlReg[ssm_pkg::CTL_FBUS_EN]) else $error("fieldbus use set while fieldbus off");
  AST_STOP_NEEDS_ENC: assert property (@(posedge clk_sys) disable iff (!nrst)
    stopReg |-> $past(stopAllowed)) else $error("stop active without arming and encoder");
  AST_AUTO_CLEAR: assert property (@(posedge clk_sys) disable iff (!nrst)
    (stopReg && !trigIn && !restartBehReg) |=> !stopReg) else $error("auto restart did not clear");
  AST_MANUAL_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    (stopReg && stopAllowed && restartBehReg && !ackIn) |=> stopReg) else $error("manual stop cleared");
  AST_DWELL_BEFORE_MON: assert property (@(posedge clk_sys) disable iff (!nrst)
    (spdReg == ssm_pkg::SPD_WAIT && spdNext == ssm_pkg::SPD_MONITOR) |-> dwellTmr.elapsed >= dwellReg)
    else $error("monitor entered early");
  AST_DEADLINE_FAULT: assert property (@(posedge clk_sys) disable iff (!nrst)
    (spdReg == ssm_pkg::SPD_WAIT && ctlReg[ssm_pkg::CTL_SPEED_REQ] && !inLimit &&
     deadTmr.elapsed >= deadlineReg)
    |=> faulted) else $error("deadline expiry missed");
  AST_VIOL: assert property (@(posedge clk_sys) disable iff (!nrst)
    (stopReg && posDelta > posWinReg) |=> violReg) else $error("window breach missed");
  AST_REACTION: assert property (@(posedge clk_sys) disable iff (!nrst)
    faulted |-> $onehot({torqueOffReq, stopOneReq, stopTwoReq})) else $error("reaction not unique");
  AST_TICK: assert property (@(posedge clk_sys) disable iff (!nrst)
    msTick |=> !msTick) else $error("tick longer than one cycle");
endmodule : safe_speed_standstill_monitor
`default_nettype wire

/* common/ssm_pkg.sv */
`default_nettype none
package ssm_pkg;
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned TICK_MS         = 1;
  localparam int unsigned CYCLES_PER_MS   = CLK_HZ / 1000 * TICK_MS;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_DWELL        = 8'h00;
  localparam logic [7:0] OFS_DEADLINE     = 8'h04;
  localparam logic [7:0] OFS_THRESHOLD    = 8'h08;
  localparam logic [7:0] OFS_FBUS_USE     = 8'h0C;
  localparam logic [7:0] OFS_ARMING       = 8'h10;
  localparam logic [7:0] OFS_POS_WINDOW   = 8'h14;
  localparam logic [7:0] OFS_RESTART_BEH  = 8'h18;
  localparam logic [7:0] OFS_ACK_SELECT   = 8'h1C;
  localparam logic [7:0] OFS_TRIG_SELECT  = 8'h20;
  localparam logic [7:0] OFS_FAULT_ACTION = 8'h24;
  localparam logic [7:0] OFS_CONTROL      = 8'h28;
  localparam logic [7:0] OFS_STATUS       = 8'h2C;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h34;
  // reset values
  localparam logic [31:0] RST_DWELL        = 32'h0000_0001;
  localparam logic [31:0] RST_DEADLINE     = 32'h0000_0002;
  localparam logic [31:0] RST_THRESHOLD    = 32'h0000_0001;
  localparam logic [31:0] RST_POS_WINDOW   = 32'h0000_0001;
  localparam logic [1:0]  RST_FAULT_ACTION = 2'h1;
  // legal ranges
  localparam logic [31:0] DWELL_MIN    = 32'h0000_0001;
  localparam logic [31:0] DEADLINE_MIN = 32'h0000_0002;
  localparam logic [31:0] TIME_MAX     = 32'h0000_EA60;
  // input select codes
  localparam logic [2:0] SEL_NONE  = 3'h0;
  localparam logic [2:0] SEL_DUAL12 = 3'h5;
  localparam logic [2:0] SEL_DUAL34 = 3'h6;
  // fault reaction codes
  localparam logic [1:0] REACT_TORQUE_OFF = 2'h1;
  localparam logic [1:0] REACT_STOP_ONE   = 2'h2;
  localparam logic [1:0] REACT_STOP_TWO   = 2'h3;
  // control / interrupt bit positions
  localparam int unsigned CTL_SPEED_REQ  = 0;
  localparam int unsigned CTL_ENC_OK     = 1;
  localparam int unsigned CTL_FBUS_EN    = 2;
  localparam int unsigned IRQ_FAULT      = 0;
  localparam int unsigned IRQ_MONITOR    = 1;
  localparam int unsigned IRQ_STOP_ON    = 2;
  localparam int unsigned IRQ_STOP_VIOL  = 3;
  localparam int unsigned IRQ_W          = 4;
  typedef enum logic [1:0] {SPD_IDLE, SPD_WAIT, SPD_MONITOR, SPD_FAULT} speed_state_e;
endpackage : ssm_pkg
`default_nettype wire

/* common/ms_timer_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ms_timer_if;
  logic        run;      // counting enabled; low restarts
  logic        tick;     // one millisecond pulse
  logic [31:0] elapsed;  // tick pulses counted since run rose
  modport owner (output run, output tick, input elapsed);
  modport timer (input run, input tick, output elapsed);
endinterface : ms_timer_if
`default_nettype wire

/* hdl/ms_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module ms_timer (
  input  wire logic    clk_sys,  // system clock
  input  wire logic    nrst,     // async reset, active low
  ms_timer_if.timer    tmr       // run / tick in, elapsed out
);
  logic [31:0] elapsed_reg;
  logic [31:0] elapsed_next;

  // saturates so a long stall never wraps back to a small count
  always_comb begin
    elapsed_next = elapsed_reg;
    if (!tmr.run) begin
      elapsed_next = 32'h0000_0000;
    end else if (tmr.tick && elapsed_reg != 32'hFFFF_FFFF) begin
      elapsed_next = elapsed_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      elapsed_reg <= 32'h0000_0000;
    end else begin
      elapsed_reg <= elapsed_next;
    end
  end

  assign tmr.elapsed = elapsed_reg;
endmodule : ms_timer
`default_nettype wire

/* tb/axis_sensor_model.sv */
`timescale 1ns/1ps
`default_nettype none
module axis_sensor_model (
  input  wire logic        clk_sys,   // system clock
  input  wire logic [3:0]  pinCmd,    // wanted safe input levels
  input  wire logic [31:0] speedCmd,  // wanted speed magnitude
  input  wire logic [31:0] posCmd,    // wanted position drift
  output logic [3:0]       safeInPin, // safe inputs, async
  output logic [31:0]      speedAbs,  // encoder speed
  output logic [31:0]      posDelta   // encoder drift
);
  initial begin
    safeInPin = 4'h0;
    speedAbs  = 32'h0;
    posDelta  = 32'h0;
  end
  // safe inputs move off the clock edge, so the block's synchroniser is really exercised
  always @(pinCmd) safeInPin <= #3 pinCmd;
  always @(posedge clk_sys) begin
    speedAbs <= speedCmd;
    posDelta <= posCmd;
  end
endmodule : axis_sensor_model
`default_nettype wire

/* tb/tb_safe_speed_standstill_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_safe_speed_standstill_monitor;
  localparam int MS = 10;
  logic clk_sys, nrst, regWr, regRd, rdPend;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata, speedCmd, posCmd, speedAbs, posDelta;
  logic [3:0] pinCmd, safeInPin;
  logic speedFault, torqueOffReq, stopOneReq, stopTwoReq;
  logic speedMonitor, stopActive, stopViolation, irq;
  logic [31:0] expQ[$];
  int n_errors, checks, n;
  logic [3:0] pats[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hC};

  safe_speed_standstill_monitor #(.CYCLES_MS(MS)) uut (
    .clk_sys(clk_sys), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .safeInPin(safeInPin),
    .speedAbs(speedAbs), .posDelta(posDelta), .speedFault(speedFault),
    .torqueOffReq(torqueOffReq), .stopOneReq(stopOneReq), .stopTwoReq(stopTwoReq),
    .speedMonitor(speedMonitor), .stopActive(stopActive),
    .stopViolation(stopViolation), .irq(irq));
  axis_sensor_model sensors (.clk_sys(clk_sys), .pinCmd(pinCmd), .speedCmd(speedCmd),
    .posCmd(posCmd), .safeInPin(safeInPin), .speedAbs(speedAbs), .posDelta(posDelta));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task automatic fail(input string m);
    n_errors++;
    $display("CHECK FAILED t=%0t %s", $time, m);
  endtask : fail
  task automatic cmpBit(input logic got, input logic exp, input string m);
    checks++;
    if (got !== exp) fail(m);
  endtask : cmpBit
  task automatic cmpReg(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask : cmpReg
  // read data stand only in the cycle after the strobe, so the monitor samples exactly then
  always @(posedge clk_sys) begin
    if (rdPend) cmpReg(regRdata, expQ.pop_front());
    rdPend <= regRd;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regRd <= 1'b1;
    expQ.push_back(e);
    @(posedge clk_sys);
    regRd <= 1'b0;
  endtask : rd
  function automatic logic sig(input int i);
    case (i)
      0: return speedMonitor;
      1: return speedFault;
      default: return stopActive;
    endcase
  endfunction : sig
  task automatic waitHigh(input int i, input int lim, output int c);
    c = 0;
    while (sig(i) !== 1'b1 && c < lim) begin
      @(posedge clk_sys);
      c++;
    end
    #1;
  endtask : waitHigh
  task automatic pins(input logic [3:0] p, input logic e);
    @(posedge clk_sys);
    pinCmd <= p;
    repeat (6) @(posedge clk_sys);
    #1 cmpBit(stopActive, e, "stop state");
  endtask : pins
  task automatic end_sim();
    $display("errors=%0d checks=%0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  initial begin
    #(30000 * 8);
    fail("watchdog");
    end_sim();
  end

  initial begin
    {nrst, regWr, regRd, regAddr, regWdata} = '0;
    {pinCmd, speedCmd, posCmd, n_errors, checks} = '0;
    void'($urandom(32'h144B));
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h2);
    rd(8'h08, 32'h1);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h1);
    rd(8'h18, 32'h0);
    rd(8'h1C, 32'h0);
    rd(8'h24, 32'h1);
    rd(8'h3C, 32'h0);
    // out-of-range writes must leave the old value in place
    wr(8'h00, 32'h0); wr(8'h00, 32'h0000_EA61); rd(8'h00, 32'h1);
    wr(8'h00, 32'h0000_EA60); rd(8'h00, 32'h0000_EA60);
    wr(8'h04, 32'h1); rd(8'h04, 32'h2);
    wr(8'h08, 32'h0); rd(8'h08, 32'h1);
    wr(8'h14, 32'h8000_0000); rd(8'h14, 32'h1);
    wr(8'h20, 32'h7); rd(8'h20, 32'h0);
    wr(8'h24, 32'h0); rd(8'h24, 32'h1);
    wr(8'h0C, 32'h1); rd(8'h0C, 32'h0);
    wr(8'h28, 32'h4); wr(8'h0C, 32'h1); rd(8'h0C, 32'h1);
    // limited speed: dwell 3 ms then final state
    wr(8'h00, 32'h3); wr(8'h04, 32'h14); wr(8'h08, 32'h64);
    speedCmd <= $urandom_range(99, 0);
    wr(8'h28, 32'h3);
    waitHigh(0, 100, n);
    cmpBit(n >= 2 * MS && n <= 5 * MS, 1'b1, "dwell timing");
    cmpBit(speedFault, 1'b0, "early fault");
    rd(8'h30, 32'h2);
    cmpBit(irq, 1'b0, "masked irq");
    wr(8'h34, 32'h2);
    #1 cmpBit(irq, 1'b1, "unmasked irq");
    wr(8'h30, 32'h2);
    #1 cmpBit(irq, 1'b0, "cleared irq");
    speedCmd <= 32'h64;
    waitHigh(1, 5, n);
    cmpBit(speedFault, 1'b1, "leave limit");
    cmpBit(torqueOffReq, 1'b1, "default reaction");
    // deadline expiry with every reaction code
    wr(8'h04, 32'h5);
    for (int c = 1; c <= 3; c++) begin
      wr(8'h28, 32'h2);
      // the state register sees the withdrawn request one edge after the write lands
      @(posedge clk_sys);
      #1 cmpBit(speedFault, 1'b0, "fault held after release");
      wr(8'h24, c);
      speedCmd <= 32'h64 + $urandom_range(500, 0);
      wr(8'h28, 32'h3);
      waitHigh(1, 100, n);
      cmpBit(n >= 4 * MS && n <= 7 * MS, 1'b1, "deadline timing");
      cmpBit(torqueOffReq, c == 1, "reaction one");
      cmpBit(stopOneReq, c == 2, "reaction two");
      cmpBit(stopTwoReq, c == 3, "reaction three");
    end
    // stop function: arming and encoder gate it
    wr(8'h28, 32'h0); wr(8'h20, 32'h1); wr(8'h10, 32'h1);
    pins(4'h1, 1'b0);
    pins(4'h0, 1'b0);
    wr(8'h28, 32'h2); wr(8'h10, 32'h0);
    pins(4'h1, 1'b0);
    pins(4'h0, 1'b0);
    wr(8'h10, 32'h1);
    for (int c = 1; c <= 6; c++) begin
      wr(8'h20, c);
      if (c >= 5) pins(pats[c-1] & -pats[c-1], 1'b0);
      pins(pats[c-1], 1'b1);
      pins(4'h0, 1'b0);
    end
    // standstill window during the stop
    wr(8'h20, 32'h3);
    pins(4'h4, 1'b1);
    wr(8'h14, 32'h4);
    posCmd <= 32'h4;
    repeat (3) @(posedge clk_sys);
    #1 cmpBit(stopViolation, 1'b0, "inside window");
    posCmd <= 32'h5;
    repeat (3) @(posedge clk_sys);
    #1 cmpBit(stopViolation, 1'b1, "outside window");
    posCmd <= 32'h0;
    rd(8'h2C, 32'h0000_004C);
    // manual restart with dual acknowledge on inputs one and two
    wr(8'h18, 32'h1); wr(8'h1C, 32'h5);
    pins(4'h0, 1'b1);
    pins(4'h1, 1'b1);
    pins(4'h3, 1'b0);
    pins(4'h0, 1'b0);
    repeat (4) @(posedge clk_sys);
    end_sim();
  end
endmodule : tb_safe_speed_standstill_monitor
`default_nettype wire
